// ---- mel_pkg.sv ----
package mel_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [3:0] IDX_SYS_ERR    = 4'h4;
    localparam logic [3:0] IDX_FAIL_SYN   = 4'h6;
    localparam logic [3:0] IDX_DIAG_CTRL  = 4'h8;
    localparam logic [3:0] IDX_DIAG_DATA  = 4'ha;
    localparam logic [3:0] IDX_PROC_ERR   = 4'hc;
    localparam logic [3:0] IDX_IDENT      = 4'he;

    // system_error_log fields
    localparam int SE_CODE_LSB   = 0;
    localparam int SE_MULTI      = 3;
    localparam int SE_CORR       = 4;
    localparam int SE_PROC       = 5;
    localparam int SE_MEMV       = 6;
    localparam int SE_RMW        = 7;
    localparam logic [7:0] SE_ONES = 8'hff;

    // error codes
    localparam logic [2:0] CODE_RSVD      = 3'h0;
    localparam logic [2:0] CODE_MC_ADDR   = 3'h1;
    localparam logic [2:0] CODE_MC_DATA   = 3'h2;
    localparam logic [2:0] CODE_NOT_PRES  = 3'h3;
    localparam logic [2:0] CODE_SA_ADDR   = 3'h4;
    localparam logic [2:0] CODE_SA_DATA   = 3'h5;
    localparam logic [2:0] CODE_UNCORR    = 3'h6;
    localparam logic [2:0] CODE_NONE      = 3'h7;

    // failing_access_syndrome fields
    localparam int FS_SYN_LSB    = 0;
    localparam int FS_ADDR_LSB   = 7;
    localparam int FS_ID_LSB     = 11;

    // diag_mode_control fields
    localparam int DC_BYPASS     = 0;
    localparam int DC_FULLWORD   = 1;
    localparam int DC_INTERLEAVE = 2;

    // per_processor_error_flags fields
    localparam int PF_PAR_LSB    = 0;
    localparam int PF_FATAL_LSB  = 8;
    localparam int NUM_CPU       = 6;

    localparam logic [7:0]  DD_ONES      = 8'hff;
    localparam logic [15:0] IDENT_VALUE  = 16'h0001;

    typedef struct packed {
        logic       mc_addr_parity;
        logic       mc_data_parity;
        logic       not_present;
        logic       sa_addr_parity;
        logic       sa_data_parity;
        logic       uncorrectable;
        logic       correctable;
        logic       rmw_timeout;
        logic [2:0] requester_id;
        logic [4:0] storage_module_id;
        logic [3:0] addr_hi;
        logic [6:0] correction_syndrome;
    } mel_err_report_t;

    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
        logic [2:0]  code;
        logic        multi;
        logic        corr;
        logic        processor_fault_flag;
        logic        memory_fault_valid;
        logic        rmw;
        logic        fatal_seen;
        logic [15:0] syn;
        logic        bypass;
        logic        fullword;
        logic [7:0]  ddata;
        logic [5:0]  par;
        logic [5:0]  fatal;
        logic [5:0]  fatal_prev;
    } mel_state_t;

endpackage : mel_pkg

// ---- mel_error_log.sv ----
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps

module mel_error_log (
    input  wire logic                     core_clk_in,
    input  wire logic                     resetn_in,
    input  wire logic                     wb_cyc_in,
    input  wire logic                     wb_stb_in,
    input  wire logic                     wb_we_in,
    input  wire logic [7:0]               wb_adr_in,
    input  wire logic [3:0]               wb_sel_in,
    input  wire logic [31:0]              wb_dat_in,
    output logic      [31:0]              wb_dat_out,
    output logic                          wb_ack_out,
    input  wire mel_pkg::mel_err_report_t err_report_in,
    input  wire logic [5:0]               cpu_parity_err_in,
    input  wire logic [5:0]               cpu_fatal_in,
    input  wire logic                     interleaved_in,
    output logic                          addr_map_bypass_out,
    output logic                          full_word_access_out
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [2:0] count_ones(input logic [6:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 7; i++) begin
            n = n + {2'h0, v[i]};
        end
        return n;
    endfunction : count_ones

    // lowest code wins when several arrive together
    function automatic logic [2:0] first_code(input logic [5:0] ev);
        logic [2:0] c;
        c = mel_pkg::CODE_NONE;
        for (int i = 5; i >= 0; i--) begin
            if (ev[i]) begin
                c = 3'(i + 1);
            end
        end
        return c;
    endfunction : first_code

    // syndrome register layout: module id, upper address bits, syndrome
    function automatic logic [15:0] pack_syn(input logic [4:0] id,
                                             input logic [3:0] hi,
                                             input logic [6:0] syn);
        logic [15:0] w;
        w = 16'h0000;
        w[mel_pkg::FS_ID_LSB +: 5]   = id;
        w[mel_pkg::FS_ADDR_LSB +: 4] = hi;
        w[mel_pkg::FS_SYN_LSB +: 7]  = syn;
        return w;
    endfunction : pack_syn

    // reset image: empty log, no-error code, diagnostics off
    function automatic mel_pkg::mel_state_t reset_state();
        mel_pkg::mel_state_t s;
        s.ack                  = 1'b0;
        s.rdata                = 16'h0000;
        s.code                 = mel_pkg::CODE_NONE;
        s.multi                = 1'b0;
        s.corr                 = 1'b0;
        s.processor_fault_flag = 1'b0;
        s.memory_fault_valid   = 1'b0;
        s.rmw                  = 1'b0;
        s.fatal_seen           = 1'b0;
        s.syn                  = 16'h0000;
        s.bypass               = 1'b0;
        s.fullword             = 1'b0;
        s.ddata                = 8'h00;
        s.par                  = 6'h00;
        s.fatal                = 6'h00;
        s.fatal_prev           = 6'h00;
        return s;
    endfunction : reset_state

    ////////////////////////////////////////////////////////////////////////
    // state

    mel_pkg::mel_state_t q;
    mel_pkg::mel_state_t next_q;

    logic        bus_hit;
    logic        bus_wr;
    logic [3:0]  idx;
    logic        addr_ok;
    logic [5:0]  coded_ev;
    wire  [5:0]  fatal_rise;
    logic [3:0]  new_fatal;
    logic [2:0]  new_code;
    logic [15:0] rd_word;
    logic [15:0] sys_word;
    logic [15:0] dc_word;
    logic [15:0] pf_word;

    // derived terms
    logic [15:0] req_syn;
    logic [15:0] mod_syn;
    logic [15:0] corr_syn;
    wire  [5:0]  par_hold;
    logic        wr_sys;
    logic        log_open;
    logic        corr_take;

    // bus decode: index from address bits 5:2, all others zero
    // reads have no side effect, so software may read in any order;
    // only the system error write opens a new sampling period
    assign idx     = wb_adr_in[5:2];
    assign addr_ok = (wb_adr_in[7:6] == 2'h0) && (wb_adr_in[1:0] == 2'h0);
    // one access per request: ack drops the cycle after it was given
    assign bus_hit = wb_cyc_in && wb_stb_in && !q.ack;
    assign bus_wr  = bus_hit && wb_we_in && addr_ok;

    // error reports are one-cycle pulses; each high flag is one event.
    // coded events, lowest code first:
    //   mc_addr_parity -> 001    mc_data_parity -> 010
    //   not_present    -> 011    sa_addr_parity -> 100
    //   sa_data_parity -> 101    uncorrectable  -> 110
    // correctable and rmw_timeout set flags and carry no code; correctable also loads the syndrome while the log is empty
    assign coded_ev = {err_report_in.uncorrectable,
                       err_report_in.sa_data_parity,
                       err_report_in.sa_addr_parity,
                       err_report_in.not_present,
                       err_report_in.mc_data_parity,
                       err_report_in.mc_addr_parity};

    // two 3-bit counts can sum past seven, so the total is one bit wider
    assign new_fatal = {1'b0, count_ones({1'b0, coded_ev})}
                     + {1'b0, count_ones({1'b0, fatal_rise})};
    assign new_code  = first_code(coded_ev);
    assign wr_sys    = bus_wr && (idx == mel_pkg::IDX_SYS_ERR);

    ////////////////////////////////////////////////////////////////////////
    // per processor flags

    // one parity slot and one fatal slot per processor position
    for (genvar g = 0; g < mel_pkg::NUM_CPU; g++) begin : g_cpu
        // a fatal level counts toward the multiple flag once, on its rise
        assign fatal_rise[g] = cpu_fatal_in[g] && !q.fatal_prev[g];
        // a parity report in the same cycle as the clear survives it
        assign par_hold[g]   = (q.par[g] && !wr_sys) || cpu_parity_err_in[g];
    end

    ////////////////////////////////////////////////////////////////////////
    // syndrome register candidates

    // the controller parity codes name the requester, not a storage module
    assign req_syn   = pack_syn({2'h0, err_report_in.requester_id}, 4'h0, 7'h00);
    // a storage module report carries only the upper four address bits
    assign mod_syn   = pack_syn(err_report_in.storage_module_id,
                                err_report_in.addr_hi,
                                7'h00);
    assign corr_syn  = pack_syn(err_report_in.storage_module_id,
                                err_report_in.addr_hi,
                                err_report_in.correction_syndrome);
    // a correctable word owns the register only while the log is empty
    assign log_open  = (wr_sys || !q.memory_fault_valid) && !q.corr;
    assign corr_take = err_report_in.correctable && log_open;

    ////////////////////////////////////////////////////////////////////////
    // read words

    // register map, one 16-bit register per 32-bit bus word:
    //   0x10 system error log
    //        [2:0] code, 111 while nothing is logged
    //        [3] multiple fatal errors this period
    //        [4] correctable storage error
    //        [5] processor parity or fatal report
    //        [6] memory fault valid, qualifies [2:0]
    //        [7] read-modify-write timeout
    //        [15:8] read as ones
    //        any write clears the log
    //   0x18 failing access and syndrome
    //        [15:11] module id, requester id for 001/010
    //        [10:7] upper four address bits
    //        [6:0] syndrome of a correctable word
    //   0x20 diagnostic mode control
    //        [0] bypass address mapping
    //        [1] full-word check bit access
    //        [2] interleave strap, read only
    //   0x28 turnaround data, upper byte reads ones
    //   0x30 processor flags: parity [5:0], fatal [13:8]
    //   0x38 board set identity, always one
    // other addresses are acknowledged and read zero

    always_comb begin
        sys_word                            = 16'h0000;
        sys_word[15:8]                      = mel_pkg::SE_ONES;
        sys_word[mel_pkg::SE_CODE_LSB +: 3] = q.code;
        sys_word[mel_pkg::SE_MULTI]         = q.multi;
        sys_word[mel_pkg::SE_CORR]          = q.corr;
        sys_word[mel_pkg::SE_PROC]          = q.processor_fault_flag;
        sys_word[mel_pkg::SE_MEMV]          = q.memory_fault_valid;
        sys_word[mel_pkg::SE_RMW]           = q.rmw;
        dc_word = 16'h0000;
        dc_word[mel_pkg::DC_BYPASS]     = q.bypass;
        dc_word[mel_pkg::DC_FULLWORD]   = q.fullword;
        dc_word[mel_pkg::DC_INTERLEAVE] = interleaved_in;
        pf_word = 16'h0000;
        pf_word[mel_pkg::PF_PAR_LSB +: mel_pkg::NUM_CPU]   = q.par;
        pf_word[mel_pkg::PF_FATAL_LSB +: mel_pkg::NUM_CPU] = q.fatal;
        rd_word = 16'h0000;
        if (addr_ok) begin
            case (idx)
                mel_pkg::IDX_SYS_ERR: begin
                    rd_word = sys_word;
                end
                mel_pkg::IDX_FAIL_SYN: begin
                    rd_word = q.syn;
                end
                mel_pkg::IDX_DIAG_CTRL: begin
                    rd_word = dc_word;
                end
                mel_pkg::IDX_DIAG_DATA: begin
                    rd_word = {mel_pkg::DD_ONES, q.ddata};
                end
                mel_pkg::IDX_PROC_ERR: begin
                    rd_word = pf_word;
                end
                mel_pkg::IDX_IDENT: begin
                    rd_word = mel_pkg::IDENT_VALUE;
                end
                default: begin
                    rd_word = 16'h0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    // order of work inside one cycle:
    //   1. a read is answered from the state before the edge
    //   2. a system error write clears the log
    //   3. events of the same cycle are merged on top, so an
    //      event never falls into the gap of a clear, save a correctable syndrome when the cleared log held a correctable error
    //   4. the first coded error of a period owns code and
    //      syndrome; a correctable word fills the syndrome only
    //      while the log holds nothing else
    // limitation: later coded errors of the period count toward
    // the multiple flag, but their code and address are lost
    // the multiple flag counts coded errors and rising fatal
    // levels together

    always_comb begin
        next_q = q;
        next_q.ack = bus_hit;
        if (bus_hit) begin
            next_q.rdata = rd_word;
        end

        // software writes come first so that events in the same cycle win
        if (bus_wr) begin
            case (idx)
                mel_pkg::IDX_SYS_ERR: begin
                    // data is ignored; any write opens a new period
                    next_q.code                 = mel_pkg::CODE_NONE;
                    next_q.multi                = 1'b0;
                    next_q.corr                 = 1'b0;
                    next_q.processor_fault_flag = 1'b0;
                    next_q.memory_fault_valid   = 1'b0;
                    next_q.rmw                  = 1'b0;
                    next_q.fatal_seen           = 1'b0;
                    next_q.syn                  = 16'h0000;
                    next_q.par                  = 6'h00;
                end
                mel_pkg::IDX_DIAG_CTRL: begin
                    if (wb_sel_in[0]) begin
                        next_q.bypass   = wb_dat_in[mel_pkg::DC_BYPASS];
                        next_q.fullword = wb_dat_in[mel_pkg::DC_FULLWORD];
                    end
                end
                mel_pkg::IDX_DIAG_DATA: begin
                    if (wb_sel_in[0]) begin
                        next_q.ddata = wb_dat_in[7:0];
                    end
                end
                default: begin
                    next_q.ddata = next_q.ddata;
                end
            endcase
        end

        // processor reports
        // fatal flags follow the live levels one cycle late
        next_q.fatal      = cpu_fatal_in;
        next_q.fatal_prev = cpu_fatal_in;
        next_q.par        = par_hold;
        if ((|cpu_parity_err_in) || (|cpu_fatal_in)) begin
            next_q.processor_fault_flag = 1'b1;
        end

        if (err_report_in.rmw_timeout) begin
            next_q.rmw = 1'b1;
        end

        // a second fatal error, in this cycle or earlier in the period
        if ((new_fatal >= 3'h2) ||
            (next_q.fatal_seen && (new_fatal != 3'h0))) begin
            next_q.multi = 1'b1;
        end
        if (new_fatal != 3'h0) begin
            next_q.fatal_seen = 1'b1;
        end

        if (err_report_in.correctable) begin
            next_q.corr = 1'b1;
        end
        if (corr_take) begin
            next_q.syn = corr_syn;
        end

        // the first coded error of the period is kept
        if ((|coded_ev) && !next_q.memory_fault_valid) begin
            next_q.code               = new_code;
            next_q.memory_fault_valid = 1'b1;
            if ((new_code == mel_pkg::CODE_MC_ADDR) ||
                (new_code == mel_pkg::CODE_MC_DATA)) begin
                next_q.syn = req_syn;
            end else begin
                next_q.syn = mod_syn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // the whole state is one register; reset loads a constant image
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= reset_state();
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_ack_out           = q.ack;
    assign wb_dat_out           = {16'h0000, q.rdata};
    assign addr_map_bypass_out  = q.bypass;
    assign full_word_access_out = q.fullword;

endmodule : mel_error_log

// ---- mel_error_log_properties.sv ----
`timescale 1ns/10ps
module mel_props (
    input wire logic                     core_clk_in,
    input wire logic                     resetn_in,
    input wire logic                     wb_cyc_in,
    input wire logic                     wb_stb_in,
    input wire logic                     wb_we_in,
    input wire logic [7:0]               wb_adr_in,
    input wire logic [3:0]               wb_sel_in,
    input wire logic [31:0]              wb_dat_in,
    input wire logic [31:0]              wb_dat_out,
    input wire logic                     wb_ack_out,
    input wire mel_pkg::mel_err_report_t err_report_in,
    input wire logic [5:0]               cpu_parity_err_in,
    input wire logic [5:0]               cpu_fatal_in,
    input wire logic                     interleaved_in,
    input wire logic                     addr_map_bypass_out,
    input wire logic                     full_word_access_out
);
    default clocking dc @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    wire take  = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire quiet = err_report_in[26:19] == 8'h00 && cpu_parity_err_in == 6'h00 && cpu_fatal_in == 6'h00;
    sequence rd_at(logic [7:0] a);
        take && !wb_we_in && wb_adr_in == a;
    endsequence
    sequence ctl_wr;
        take && wb_we_in && wb_adr_in == 8'h20 && wb_sel_in[0];
    endsequence
    // no event may land between the clear and the read, else the log is rightly not empty
    sequence log_clear;
        take && wb_we_in && wb_adr_in == 8'h10 && quiet ##1 quiet[*2] ##1 rd_at(8'h10);
    endsequence
    ident_value_a: assert property (rd_at(8'h38) |=> wb_dat_out == 32'h1)
        else $error("identity read not one");
    code_legal_a: assert property (rd_at(8'h10) |=> wb_dat_out[2:0] != mel_pkg::CODE_RSVD)
        else $error("reserved error code read");
    proc_flag_a: assert property (((|cpu_parity_err_in) || (|cpu_fatal_in)) ##1 rd_at(8'h10)
        |=> wb_dat_out[mel_pkg::SE_PROC]) else $error("processor flag missing");
    parity_keep_a: assert property ((|cpu_parity_err_in) ##1 rd_at(8'h30)
        |=> (wb_dat_out[5:0] & $past(cpu_parity_err_in, 2)) == $past(cpu_parity_err_in, 2))
        else $error("parity flag missing");
    fatal_live_a: assert property (rd_at(8'h30) |=> wb_dat_out[13:8] == $past(cpu_fatal_in, 2))
        else $error("fatal flags not live");
    bypass_bit_a: assert property (ctl_wr |=> addr_map_bypass_out == $past(wb_dat_in[0]))
        else $error("bypass not written");
    full_word_a: assert property (ctl_wr |=> full_word_access_out == $past(wb_dat_in[1]))
        else $error("full word not written");
    interleave_bit_a: assert property (rd_at(8'h20) |=> wb_dat_out[15:0] == {13'h0,
        $past(interleaved_in), $past(full_word_access_out), $past(addr_map_bypass_out)})
        else $error("control read wrong");
    data_upper_a: assert property (rd_at(8'h28) |=> wb_dat_out[31:8] == 24'h0000ff)
        else $error("data upper byte wrong");
    clear_log_a: assert property (log_clear |=> wb_dat_out == 32'h0000ff07)
        else $error("log not cleared");
endmodule : mel_props

bind mel_error_log mel_props i_props (.core_clk_in, .resetn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .err_report_in, .cpu_parity_err_in, .cpu_fatal_in,
    .interleaved_in, .addr_map_bypass_out, .full_word_access_out);

// ---- mel_partner.sv ----
`timescale 1ns/10ps
module mel_partner (
    input  wire logic               clk_in,
    output mel_pkg::mel_err_report_t rep_out = '0,
    output logic [5:0]              par_out = 6'h00,
    output logic [5:0]              fatal_out = 6'h00
);
    logic        ev_go = 1'b0;
    logic [26:0] ev_rep;
    logic [5:0]  ev_par;
    // idle id fields toggle every cycle so a stale report never looks valid
    always @(posedge clk_in) begin
        if (ev_go) begin
            rep_out <= ev_rep;
            par_out <= ev_par;
            ev_go   <= 1'b0;
        end else begin
            rep_out <= {8'h00, ~rep_out[18:0]};
            par_out <= 6'h00;
        end
    end
    task automatic report(input logic [26:0] r, input logic [5:0] p);
        ev_rep <= r;
        ev_par <= p;
        ev_go  <= 1'b1;
        @(posedge clk_in);
    endtask : report
    task automatic set_fatal(input logic [5:0] f);
        fatal_out <= f;
    endtask : set_fatal
endmodule : mel_partner

// ---- test_memory_error_log_registers.sv ----
`timescale 1ns/10ps
module test_memory_error_log_registers;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        ileave = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        byp;
    logic        fw;
    logic [5:0]  par;
    logic [5:0]  fat;
    mel_pkg::mel_err_report_t rep;
    int          mismatches = 0;
    int          n_checks = 0;
    int          seed = 26;
    int          m_nf = 0;
    logic [2:0]  m_code = 3'h7;
    logic [4:0]  m_flg = 5'h0;
    logic        m_cs = 1'b0;
    logic [7:0]  m_dd = 8'h00;
    logic [1:0]  m_ctl = 2'b00;
    logic [5:0]  m_par = 6'h00;
    logic [5:0]  m_fat = 6'h00;
    logic [15:0] m_syn = 16'h0;
    logic [15:0] m_msk = 16'hffff;

    always #4 clk = ~clk;
    mel_error_log i_dut (.core_clk_in(clk), .resetn_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .err_report_in(rep), .cpu_parity_err_in(par), .cpu_fatal_in(fat), .interleaved_in(ileave),
        .addr_map_bypass_out(byp), .full_word_access_out(fw));
    mel_partner i_part (.clk_in(clk), .rep_out(rep), .par_out(par), .fatal_out(fat));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        n_checks++;
        if ((got & msk) !== (exp & msk)) begin
            mismatches++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                       output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, 16'h0, d, s};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        check({31'h0, ack}, 32'h1, 32'h1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        logic [31:0] q;
        bus(1'b0, a, 16'h0, 4'h0, q);
        check(q, exp, msk);
    endtask : rdc
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        logic [31:0] q;
        bus(1'b1, a, d, s, q);
    endtask : wr
    // the written value is don't-care, so random data and strobes go with it
    task automatic clear_log();
        logic [31:0] r = $random(seed);
        wr(8'h10, r[15:0], r[19:16]);
        m_code = 3'h7;
        m_flg = {2'b00, m_fat != 6'h00, 2'b00};
        {m_nf, m_cs, m_par, m_syn, m_msk} = {32'h0, 1'b0, 6'h00, 16'h0, 16'hffff};
    endtask : clear_log
    // memory-valid is left open while only a correctable error is logged
    task automatic chk_log();
        rdc(8'h10, {16'h0, 8'hff, m_flg, m_code}, (m_code == 3'h7 && m_flg[1]) ? 32'hffffffbf : '1);
        rdc(8'h18, {16'h0, m_syn}, {16'h0, m_msk});
        rdc(8'h30, {18'h0, m_fat, 2'b00, m_par}, '1);
    endtask : chk_log
    task automatic event_in(input logic [7:0] fl, input logic [18:0] f, input logic [5:0] p);
        int n = 0;
        logic [2:0] c = 3'h7;
        i_part.report({fl, f}, p);
        for (int k = 1; k <= 6; k++) begin
            if (fl[8 - k]) begin
                n++;
                c = (c == 3'h7) ? k[2:0] : c;
            end
        end
        m_flg[0] |= (n > 1) || (n > 0 && m_nf > 0);
        m_nf += n;
        if (n > 0 && m_code != 3'h7) begin
            m_msk = 16'h0;
        end else if (n > 0) begin
            m_code = c;
            m_flg[3] = 1'b1;
            m_syn = (c < 3'h3) ? {2'b00, f[18:16], 11'h0} : f[15:0];
            m_msk = (c < 3'h3) ? 16'hf800 : 16'hff80;
        end
        if (fl[1] && m_code == 3'h7 && !m_cs) begin
            {m_syn, m_msk} = {f[15:0], 16'hffff};
        end
        m_cs |= fl[1];
        m_flg = m_flg | {fl[0], 1'b0, p != 6'h00, fl[1], 1'b0};
        m_par |= p;
    endtask : event_in
    // only rising fatal levels count toward the multiple flag
    task automatic set_fatal(input logic [5:0] f);
        int n = $countones(f & ~m_fat);
        i_part.set_fatal(f);
        @(posedge clk);
        m_flg[0] |= (n > 1) || (n > 0 && m_nf > 0);
        m_nf += n;
        m_flg[2] |= (f != 6'h00);
        m_fat = f;
    endtask : set_fatal
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
    initial begin
        logic [31:0] r;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h10, 32'hff07, '1);
        clear_log();
        chk_log();
        wr(8'h38, 16'h0, 4'hf);
        rdc(8'h38, 32'h1, '1);
        wr(8'h3c, 16'hffff, 4'hf);
        rdc(8'h3c, 32'h0, '1);
        rdc(8'h28, 32'hff00, '1);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            ileave <= r[20];
            wr(8'h28, r[15:0], r[19:16]);
            wr(8'h20, r[23:8], r[19:16]);
            m_dd = r[16] ? r[7:0] : m_dd;
            m_ctl = r[16] ? r[9:8] : m_ctl;
            check({30'h0, fw, byp}, {30'h0, m_ctl}, '1);
            rdc(8'h20, {29'h0, r[20], m_ctl}, '1);
            rdc(8'h28, {16'h0, 8'hff, m_dd}, '1);
        end
        for (int k = 1; k <= 6; k++) begin
            clear_log();
            r = $random(seed);
            event_in(8'h80 >> (k - 1), r[18:0], 6'h00);
            chk_log();
        end
        clear_log();
        r = $random(seed);
        event_in(8'h02, r[18:0], 6'h00);
        event_in(8'h02, r[31:13], 6'h00);
        chk_log();
        event_in(8'h21, r[18:0], 6'h00);
        chk_log();
        event_in(8'h48, r[31:13], 6'h00);
        chk_log();
        clear_log();
        event_in(8'h48, r[18:0], 6'h00);
        chk_log();
        clear_log();
        event_in(8'h00, r[18:0], r[5:0] | 6'h01);
        rdc(8'h30, {26'h0, m_par}, '1);
        chk_log();
        set_fatal(r[13:8] | 6'h02);
        chk_log();
        clear_log();
        chk_log();
        set_fatal(6'h00);
        chk_log();
        end_sim();
    end
endmodule : test_memory_error_log_registers
